// ===== shared/dcpo_consts.vh
// offsets, field positions, reset values and masks of the channel code and pair trim block
`ifndef DCPO_CONSTS_VH
`define DCPO_CONSTS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DCPO_IDX_CODE_FIRST 7'h14
`define DCPO_IDX_CODE_LAST 7'h1B
`define DCPO_IDX_TRIM_FIRST 7'h21
`define DCPO_IDX_TRIM_SECOND 7'h22
`define DCPO_IDX_CONFIG 7'h30
`define DCPO_IDX_LEVEL_FIRST 7'h40
`define DCPO_IDX_LEVEL_LAST 7'h47

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DCPO_CODE_RESET 16'h0000
`define DCPO_TRIM_RESET 16'h0000
`define DCPO_LEVEL_RESET 16'h0000
`define DCPO_PAIR_RESET 4'h0
`define DCPO_RES_RESET 2'h0
`define DCPO_RDATA_RESET 32'h0000_0000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DCPO_CFG_PAIR_MSB 3
`define DCPO_CFG_PAIR_LSB 0
`define DCPO_CFG_RES_MSB 5
`define DCPO_CFG_RES_LSB 4
`define DCPO_TRIM_UP_MSB 15
`define DCPO_TRIM_UP_LSB 8
`define DCPO_TRIM_LO_MSB 7
`define DCPO_TRIM_LO_LSB 0

// ----------------------------------------------------------------
// resolution variants and their significant-bit masks
// ----------------------------------------------------------------
`define DCPO_RES_FULL 2'h0
`define DCPO_RES_MID 2'h1
`define DCPO_RES_LOW 2'h2
`define DCPO_CMASK_FULL 16'hFFFF
`define DCPO_CMASK_MID 16'hFFFC
`define DCPO_CMASK_LOW 16'hFFF0
`define DCPO_TMASK_FULL 8'hFF
`define DCPO_TMASK_MID 8'hFC
`define DCPO_TMASK_LOW 8'hF0

`endif

// ===== verilog/dcpo_trim_apply.v
// output levels of one channel pair: code masking and signed trim of the upper channel
`include "dcpo_consts.vh"

module dcpo_trim_apply (
  input wire [15:0] code,
  input wire [7:0] trim,
  input wire [1:0] res,
  output reg [15:0] lower_level,
  output reg [15:0] upper_level
);

  reg [15:0] cmask;
  reg [7:0] tmask;
  reg [7:0] trim_m;
  reg [17:0] sum;

  // ----------------------------------------------------------------
  // significant bits per variant
  // ----------------------------------------------------------------
  // code left-justified; trim kept in full-code LSB units with its low bits masked,
  // which rounds it down to a whole variant step without a shifter
  always @* begin
    case (res)
      `DCPO_RES_FULL: begin
        cmask = `DCPO_CMASK_FULL;
        tmask = `DCPO_TMASK_FULL;
      end
      `DCPO_RES_MID: begin
        cmask = `DCPO_CMASK_MID;
        tmask = `DCPO_TMASK_MID;
      end
      default: begin
        cmask = `DCPO_CMASK_LOW;
        tmask = `DCPO_TMASK_LOW;
      end
    endcase
    trim_m = trim & tmask;
    lower_level = code & cmask;
    // sign-extended add, then clamp to the unsigned code span
    sum = {2'b00, lower_level} + {{10{trim_m[7]}}, trim_m};
    if (sum[17]) begin
      upper_level = 16'h0000;
    end else if (sum[16]) begin
      upper_level = cmask;
    end else begin
      upper_level = sum[15:0];
    end
  end

endmodule

// ===== verilog/dcpo_regs.v
// eight channel code registers, two pair trim registers and their Avalon-MM slave
//
// Chosen here: the Avalon-MM slave port.
`include "dcpo_consts.vh"

module dcpo_regs (
  input wire MCLK,
  input wire NRST,
  input wire [8:0] ADDRESS,
  input wire READ,
  input wire WRITE,
  input wire [31:0] WRITEDATA,
  input wire [3:0] BYTEENABLE,
  output wire [31:0] READDATA,
  output wire WAITREQUEST,
  output wire [15:0] CH_LEVEL0,
  output wire [15:0] CH_LEVEL1,
  output wire [15:0] CH_LEVEL2,
  output wire [15:0] CH_LEVEL3,
  output wire [15:0] CH_LEVEL4,
  output wire [15:0] CH_LEVEL5,
  output wire [15:0] CH_LEVEL6,
  output wire [15:0] CH_LEVEL7
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg rst_meta_q;
  reg rst_n_q;

  // assert at once, release two edges later so no flop leaves reset mid-edge
  always @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  wire [6:0] idx;
  wire [6:0] code_off;
  wire req;
  wire commit_wr;
  reg wait_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;

  assign idx = ADDRESS[8:2];
  assign code_off = idx - `DCPO_IDX_CODE_FIRST;
  assign req = READ | WRITE;
  // a write lands on the edge where the master sees waitrequest low
  assign commit_wr = WRITE & ~wait_q;

  // one wait cycle per access; read data is loaded as waitrequest drops
  always @(posedge MCLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wait_q <= 1'b1;
      rdata_q <= `DCPO_RDATA_RESET;
    end else if (req && wait_q) begin
      wait_q <= 1'b0;
      rdata_q <= rdata_d;
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign WAITREQUEST = wait_q;
  assign READDATA = rdata_q;

  // ----------------------------------------------------------------
  // configuration: pair enables and resolution variant
  // ----------------------------------------------------------------
  reg [3:0] pair_en_q;
  reg [1:0] res_q;
  wire cfg_hit;

  assign cfg_hit = commit_wr && (idx == `DCPO_IDX_CONFIG) && BYTEENABLE[0];

  // pair bit k joins channels 2k and 2k+1
  always @(posedge MCLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pair_en_q <= `DCPO_PAIR_RESET;
      res_q <= `DCPO_RES_RESET;
    end else if (cfg_hit) begin
      pair_en_q <= WRITEDATA[`DCPO_CFG_PAIR_MSB:`DCPO_CFG_PAIR_LSB];
      res_q <= WRITEDATA[`DCPO_CFG_RES_MSB:`DCPO_CFG_RES_LSB];
    end
  end

  // ----------------------------------------------------------------
  // pair trim registers
  // ----------------------------------------------------------------
  reg [15:0] trim_first_q;
  reg [15:0] trim_second_q;
  wire [31:0] trim_flat;

  // byte lanes honoured so one trim field can change alone
  always @(posedge MCLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      trim_first_q <= `DCPO_TRIM_RESET;
      trim_second_q <= `DCPO_TRIM_RESET;
    end else if (commit_wr) begin
      if (idx == `DCPO_IDX_TRIM_FIRST) begin
        if (BYTEENABLE[0]) trim_first_q[7:0] <= WRITEDATA[7:0];
        if (BYTEENABLE[1]) trim_first_q[15:8] <= WRITEDATA[15:8];
      end
      if (idx == `DCPO_IDX_TRIM_SECOND) begin
        if (BYTEENABLE[0]) trim_second_q[7:0] <= WRITEDATA[7:0];
        if (BYTEENABLE[1]) trim_second_q[15:8] <= WRITEDATA[15:8];
      end
    end
  end

  // pair order 0-1, 2-3, 4-5, 6-7 in the flat vector
  assign trim_flat = {
    trim_second_q[`DCPO_TRIM_UP_MSB:`DCPO_TRIM_UP_LSB],
    trim_second_q[`DCPO_TRIM_LO_MSB:`DCPO_TRIM_LO_LSB],
    trim_first_q[`DCPO_TRIM_UP_MSB:`DCPO_TRIM_UP_LSB],
    trim_first_q[`DCPO_TRIM_LO_MSB:`DCPO_TRIM_LO_LSB]
  };

  // ----------------------------------------------------------------
  // per pair: code registers and output levels
  // ----------------------------------------------------------------
  wire [127:0] code_flat;
  wire [127:0] level_flat;

  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : pr
      reg [15:0] lo_code_q;
      reg [15:0] up_code_q;
      reg [15:0] lo_level_q;
      reg [15:0] up_level_q;
      wire lo_hit;
      wire up_hit;
      wire [15:0] lo_merged;
      wire [15:0] up_merged;
      wire [15:0] lo_new;
      wire [15:0] up_trimmed;
      wire [15:0] up_single;

      assign lo_hit = commit_wr && (code_off == 2 * p);
      assign up_hit = commit_wr && (code_off == 2 * p + 1);
      assign lo_merged = {BYTEENABLE[1] ? WRITEDATA[15:8] : lo_code_q[15:8],
                          BYTEENABLE[0] ? WRITEDATA[7:0] : lo_code_q[7:0]};
      assign up_merged = {BYTEENABLE[1] ? WRITEDATA[15:8] : up_code_q[15:8],
                          BYTEENABLE[0] ? WRITEDATA[7:0] : up_code_q[7:0]};

      // lower code drives both outputs, trimmed on the upper one
      dcpo_trim_apply u_lo (
        .code(lo_merged),
        .trim(trim_flat[8 * p + 7 -: 8]),
        .res(res_q),
        .lower_level(lo_new),
        .upper_level(up_trimmed)
      );

      // unpaired upper channel: plain masked code, no trim
      dcpo_trim_apply u_up (
        .code(up_merged),
        .trim(8'h00),
        .res(res_q),
        .lower_level(up_single),
        .upper_level()
      );

      // stored codes read back as written; upper code writes are dropped while its pair is enabled
      always @(posedge MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
          lo_code_q <= `DCPO_CODE_RESET;
          up_code_q <= `DCPO_CODE_RESET;
        end else begin
          if (lo_hit) lo_code_q <= lo_merged;
          if (up_hit && !pair_en_q[p]) up_code_q <= up_merged;
        end
      end

      // levels move only on a code write, so a trim change waits for a rewrite
      always @(posedge MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
          lo_level_q <= `DCPO_LEVEL_RESET;
          up_level_q <= `DCPO_LEVEL_RESET;
        end else begin
          if (lo_hit) lo_level_q <= lo_new;
          if (pair_en_q[p]) begin
            if (lo_hit) up_level_q <= up_trimmed;
          end else if (up_hit) begin
            up_level_q <= up_single;
          end
        end
      end

      assign code_flat[32 * p + 31 -: 32] = {up_code_q, lo_code_q};
      assign level_flat[32 * p + 31 -: 32] = {up_level_q, lo_level_q};
    end
  endgenerate

  // ----------------------------------------------------------------
  // read mux; unmapped indices read zero
  // ----------------------------------------------------------------
  always @* begin
    rdata_d = `DCPO_RDATA_RESET;
    if (idx >= `DCPO_IDX_CODE_FIRST && idx <= `DCPO_IDX_CODE_LAST) begin
      rdata_d[15:0] = code_flat[16 * code_off[2:0] +: 16];
    end else if (idx == `DCPO_IDX_TRIM_FIRST) begin
      rdata_d[15:0] = trim_first_q;
    end else if (idx == `DCPO_IDX_TRIM_SECOND) begin
      rdata_d[15:0] = trim_second_q;
    end else if (idx == `DCPO_IDX_CONFIG) begin
      rdata_d[`DCPO_CFG_PAIR_MSB:`DCPO_CFG_PAIR_LSB] = pair_en_q;
      rdata_d[`DCPO_CFG_RES_MSB:`DCPO_CFG_RES_LSB] = res_q;
    end else if (idx >= `DCPO_IDX_LEVEL_FIRST && idx <= `DCPO_IDX_LEVEL_LAST) begin
      rdata_d[15:0] = level_flat[16 * idx[2:0] +: 16];
    end
  end

  // ----------------------------------------------------------------
  // channel level outputs, straight from the level flops
  // ----------------------------------------------------------------
  assign CH_LEVEL0 = level_flat[15:0];
  assign CH_LEVEL1 = level_flat[31:16];
  assign CH_LEVEL2 = level_flat[47:32];
  assign CH_LEVEL3 = level_flat[63:48];
  assign CH_LEVEL4 = level_flat[79:64];
  assign CH_LEVEL5 = level_flat[95:80];
  assign CH_LEVEL6 = level_flat[111:96];
  assign CH_LEVEL7 = level_flat[127:112];

endmodule

// ===== verification/dcpo_regs_props.sv
// concurrent checks on the bus answer and channel levels of the code and trim block
module dcpo_regs_props (
  input wire MCLK,
  input wire NRST,
  input wire [8:0] ADDRESS,
  input wire READ,
  input wire WRITE,
  input wire [31:0] WRITEDATA,
  input wire [3:0] BYTEENABLE,
  input wire [31:0] READDATA,
  input wire WAITREQUEST,
  input wire [15:0] CH_LEVEL0,
  input wire [15:0] CH_LEVEL1,
  input wire [15:0] CH_LEVEL3
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // one clock domain, raw reset disables everything
  // ----------------------------------------------------------------
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
  property p_answer; (READ || WRITE) && WAITREQUEST |=> !WAITREQUEST; endproperty
  a_answer: assert property (p_answer) else $error("request not answered next cycle");
  property p_pulse; !WAITREQUEST |=> WAITREQUEST; endproperty
  a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
  property p_cause; !WAITREQUEST |-> $past(READ) || $past(WRITE); endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_stand; WAITREQUEST && $past(WAITREQUEST) |-> $stable(READDATA); endproperty
  a_stand: assert property (p_stand) else $error("read data moved between answers");
  property p_unmapped;
    READ && !WAITREQUEST && ADDRESS[8:2] < 7'h14 |-> READDATA == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // low four bits may be masked by the variant, the upper twelve never are
  property p_code0;
    WRITE && !WAITREQUEST && ADDRESS[8:2] == 7'h14 && BYTEENABLE[1:0] == 2'h3
      |=> ({16'h0000, CH_LEVEL0} | 32'h0000_000F)
        == (($past(WRITEDATA) & 32'h0000_FFFF) | 32'h0000_000F);
  endproperty
  a_code0: assert property (p_code0) else $error("channel 0 level not the written code");
  property p_lvl_cause; $changed(CH_LEVEL1) |-> $past(WRITE) && !$past(WAITREQUEST); endproperty
  a_lvl_cause: assert property (p_lvl_cause) else $error("level moved without a write");
  property p_trim;
    WRITE && !WAITREQUEST && ADDRESS[8:2] == 7'h21
      |=> $stable(CH_LEVEL1) && $stable(CH_LEVEL3);
  endproperty
  a_trim: assert property (p_trim) else $error("trim write moved a level");
endmodule

bind dcpo_regs dcpo_regs_props i_props (.MCLK(MCLK), .NRST(NRST), .ADDRESS(ADDRESS), .READ(READ),
  .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
  .WAITREQUEST(WAITREQUEST), .CH_LEVEL0(CH_LEVEL0), .CH_LEVEL1(CH_LEVEL1), .CH_LEVEL3(CH_LEVEL3));

// ===== verification/tb_dac_code_and_pair_offset_regs.sv
// self-checking bench for the channel code and pair trim registers
module tb_dac_code_and_pair_offset_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK = 1'b0;
  logic NRST = 1'b0;
  logic [8:0] ADDRESS = 9'h000;
  logic READ = 1'b0;
  logic WRITE = 1'b0;
  logic [31:0] WRITEDATA = 32'h0000_0000;
  logic [3:0] BYTEENABLE = 4'hF;
  wire [31:0] READDATA;
  wire WAITREQUEST;
  wire [15:0] lvl [0:7];
  int mismatches = 0;
  int tests_run = 0;

  dcpo_regs i_dut (.MCLK(MCLK), .NRST(NRST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
    .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .CH_LEVEL0(lvl[0]), .CH_LEVEL1(lvl[1]), .CH_LEVEL2(lvl[2]),
    .CH_LEVEL3(lvl[3]), .CH_LEVEL4(lvl[4]), .CH_LEVEL5(lvl[5]), .CH_LEVEL6(lvl[6]),
    .CH_LEVEL7(lvl[7]));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  // 4 ns period
  always #2 MCLK = ~MCLK;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one bus access; request stands until the rising edge that sees waitrequest low
  task automatic bus(input logic is_wr, input logic [6:0] idx, input logic [15:0] d,
                     output logic [31:0] rd);
    @(posedge MCLK);
    READ <= !is_wr;
    WRITE <= is_wr;
    ADDRESS <= {idx, 2'b00};
    WRITEDATA <= {16'h0000, d};
    @(posedge MCLK);
    while (WAITREQUEST !== 1'b0) @(posedge MCLK);
    rd = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] idx, input logic [15:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask

  task automatic rdchk(input logic [6:0] idx, input logic [15:0] e);
    logic [31:0] r;
    bus(1'b0, idx, 16'h0000, r);
    check(r, {16'h0000, e});
  endtask

  task automatic lv(input int ch, input logic [15:0] e);
    @(negedge MCLK);
    check({16'h0000, lvl[ch]}, {16'h0000, e});
  endtask

  function automatic logic [15:0] pat(input logic [6:0] idx);
    return {1'b0, idx, 1'b1, ~idx};
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_readback;
    logic [6:0] idx;
    for (int i = 0; i < 10; i++) begin
      idx = (i < 8) ? 7'h14 + i[6:0] : 7'h19 + i[6:0];
      rdchk(idx, 16'h0000);
      wr(idx, pat(idx));
      rdchk(idx, pat(idx));
    end
    wr(7'h01, 16'hFFFF);
    rdchk(7'h01, 16'h0000);
    $display("readback done");
  endtask

  // ignored low code bits: masked on the level, kept raw in the register
  task automatic t_variant;
    logic [15:0] e [4] = '{16'h1237, 16'h1234, 16'h1230, 16'h1230};
    for (int v = 0; v < 4; v++) begin
      wr(7'h30, {10'h000, v[1:0], 4'h0});
      wr(7'h14, 16'h1237);
      lv(0, e[v]);
      rdchk(7'h14, 16'h1237);
    end
    $display("variant done");
  endtask

  // trim 0x8F and 0x7F lose their low bits in the narrower variants
  task automatic t_trim;
    logic [15:0] ng [3] = '{16'h0F8F, 16'h0F8C, 16'h0F80};
    logic [15:0] ps [3] = '{16'h107F, 16'h107C, 16'h1070};
    for (int v = 0; v < 3; v++) begin
      wr(7'h30, {10'h000, v[1:0], 4'h1});
      wr(7'h21, 16'h008F);
      wr(7'h14, 16'h1000);
      lv(0, 16'h1000);
      lv(1, ng[v]);
      wr(7'h14, 16'h0040);
      lv(1, 16'h0000);
      wr(7'h21, 16'h007F);
      lv(1, 16'h0000);
      wr(7'h14, 16'h1000);
      lv(1, ps[v]);
      wr(7'h15, 16'hFFFF);
      rdchk(7'h15, pat(7'h15));
      lv(1, ps[v]);
    end
    $display("trim done");
  endtask

  task automatic t_pairs;
    wr(7'h30, 16'h000F);
    rdchk(7'h30, 16'h000F);
    for (int k = 0; k < 4; k++) begin
      wr(7'h21 + k[6:0] / 2, k[0] ? 16'h1000 : 16'h0010);
      wr(7'h14 + 2 * k[6:0], 16'h4000);
      lv(2 * k, 16'h4000);
      lv(2 * k + 1, 16'h4010);
      rdchk(7'h41 + {k[5:0], 1'b0}, 16'h4010);
    end
    $display("pairs done");
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  // reset for ten cycles, then room for the two-flop release
  initial begin
    repeat (10) @(posedge MCLK);
    NRST <= 1'b1;
    repeat (3) @(posedge MCLK);
    t_readback();
    t_variant();
    t_trim();
    t_pairs();
    results();
  end

  // about 80 accesses of a few cycles each; 5000 cycles is ample
  initial begin
    #20000;
    mismatches++;
    results();
  end
endmodule
